// File: vfd_pkg.sv
package vfd_pkg;
    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] CTRL_OFS = 8'h00;     // display_control_reg
    localparam logic [7:0] FMT_OFS = 8'h04;      // display_format_reg
    localparam logic [7:0] CFG_OFS = 8'h08;      // scan_config_status
    localparam logic [7:0] P8_OFS = 8'h0c;       // Port 8 output latch
    localparam logic [7:0] P9_OFS = 8'h10;       // Port 9 output latch
    localparam logic [7:0] MEM_OFS = 8'h80;      // Display memory window, 96 bytes, one per address
    localparam int MEM_BYTES = 96;
    localparam logic [15:0] MEM_CPU_BASE = 16'hfa00; // Display memory as the CPU sees it
    localparam logic [15:0] MEM_CPU_LAST = 16'hfa5f;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h10;
    localparam logic [7:0] FMT_RST = 8'h01;
    localparam logic [7:0] CFG_RST = 8'h00;
    // Field positions
    localparam int EN_BIT = 7;
    localparam int KSF_BIT = 7;
    localparam int KSM_BIT = 6;
    localparam int CFG_WMASK_BITS = 8'h43;
    localparam logic [5:0] OUT_CODE_MIN = 6'h10; // 17 outputs
    localparam logic [5:0] OUT_CODE_MAX = 6'h18; // 25 outputs
    localparam int NOUT = 25;
    // Slot period: 2^12, 2^11, 2^10 main clock periods
    localparam int PER_LOG2_MAX = 12;
    localparam logic [12:0] PER_0 = 13'h1000;
    localparam logic [12:0] PER_1 = 13'h0800;
    localparam logic [12:0] PER_2 = 13'h0400;
    // Sequencer states
    typedef enum logic [1:0] {VFD_IDLE, VFD_FETCH, VFD_SHOW} vfd_state_t;
    // Complete block state
    typedef struct packed {
        vfd_state_t st;
        logic [7:0] ctrl;
        logic [7:0] fmt;
        logic [7:0] cfg;
        logic [7:0] p8;
        logic [7:0] p9;
        logic [12:0] cnt;     // Cycle within slot
        logic [4:0] slot;     // Current slot index
        logic ks;             // Key-scan slot active
        logic [1:0] fidx;     // Byte being fetched
        logic [6:0] faddr;    // Fetch address
        logic [31:0] shadow;  // Data gathered for the slot
        logic [24:0] dout;
        logic ack;
        logic [7:0] rdat;
    } vfd_regs_t;
endpackage

// File: vfd_scan_ctrl.sv
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module vfd_scan_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [vfd_pkg::NOUT-1:0] display_out_o,
    output logic key_scan_active_o
);
    import vfd_pkg::*;

    vfd_regs_t q, d;
    // Display memory; CPU port and scan port share one array
    // The scan port never writes, so CPU writes need no arbitration
    // Bytes past the active blocks stay plain storage for software
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] mem_rd;                 // Scan-side read data
    logic [7:0] cpu_rd;                 // CPU-side read data
    logic bus_req;                      // New bus access this cycle
    logic mem_hit;                      // Access falls in the memory window
    logic [6:0] mem_idx;                // Byte index for CPU access
    logic [5:0] nout;                   // Active output count, 17..25 for codes 10h-18h
    logic [1:0] bpb;                    // Bytes per block minus one
    logic [4:0] nslot;                  // Slots per frame
    logic [12:0] period;                // Slot length in clocks
    logic [12:0] blank_half;            // Blanking cycles at each end
    logic [24:0] out_mask;              // Outputs used for display
    logic [24:0] port_vals;             // Port latches on outputs 9-24

    // A request is taken once; the ack cycle itself is not a new access
    assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
    // Memory bytes sit one per address so all 96 fit the 8-bit bus
    assign mem_hit = wb_adr_i >= MEM_OFS;
    // Window is 128 addresses wide; the top bit of the offset is always zero
    assign mem_idx = 7'(wb_adr_i - MEM_OFS);

    // Memory array: CPU write port plus two read ports
    // Addresses beyond the 96 bytes are dropped, not wrapped
    always_ff @(posedge clk_i) begin
        if (bus_req && wb_we_i && mem_hit && wb_sel_i[0] && mem_idx < 7'(MEM_BYTES)) begin
            mem[mem_idx] <= wb_dat_i[7:0];
        end
    end
    assign mem_rd = mem[q.faddr];
    assign cpu_rd = (mem_idx < 7'(MEM_BYTES)) ? mem[mem_idx] : 8'h00;

    // Decode configuration fields
    // Prohibited codes are not trapped; nout is just the code plus one, modulo 64
    // Fields are meant to change only while the scan is stopped
    always_comb begin
        nout = 6'(q.ctrl[5:0] - OUT_CODE_MIN) + 6'd17;
        bpb = (nout > 6'd24) ? 2'd3 : 2'd2; // (bytes per block minus one)
        nslot = q.fmt[4:0] + 5'd1;
        case (q.cfg[1:0])
            2'b00: period = PER_0;
            2'b01: period = PER_1;
            default: period = PER_2;
        endcase
        // Half of width: width is 1/16 or 2k/16; each end gets half
        case (q.fmt[7:5])
            3'd0: blank_half = period >> 5;
            default: blank_half = 13'((period >> 4) * 13'(q.fmt[7:5]));
        endcase
    end

    // Per-output masks; generate over the 25 pins
    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi++) begin : g_pin
            assign out_mask[gi] = (6'(gi) < nout);
            if (gi >= 9 && gi <= 16) begin : g_p9
                assign port_vals[gi] = q.p9[16 - gi];
            end else if (gi >= 17) begin : g_p8
                assign port_vals[gi] = q.p8[24 - gi];
            end else begin : g_none
                assign port_vals[gi] = 1'b0;
            end
        end
    endgenerate

    // Next-state logic for bus, config and scan sequencer
    always_comb begin
        d = q;
        d.ack = bus_req;
        d.rdat = 8'h00;
        // Register bus: single-cycle ack, unmapped reads zero
        if (bus_req) begin
            if (mem_hit) begin
                d.rdat = cpu_rd;
            end else begin
                case (wb_adr_i)
                    CTRL_OFS: d.rdat = q.ctrl;
                    FMT_OFS: d.rdat = q.fmt;
                    CFG_OFS: d.rdat = q.cfg;
                    P8_OFS: d.rdat = q.p8;
                    P9_OFS: d.rdat = q.p9;
                    default: d.rdat = 8'h00;
                endcase
            end
            if (wb_we_i && wb_sel_i[0]) begin
                case (wb_adr_i)
                    CTRL_OFS: d.ctrl = wb_dat_i[7:0];
                    FMT_OFS: d.fmt = wb_dat_i[7:0];
                    // Flag bit ignores writes, reserved bits stay zero
                    CFG_OFS: d.cfg = (wb_dat_i[7:0] & 8'(CFG_WMASK_BITS)) | (q.cfg & 8'h80);
                    P8_OFS: d.p8 = wb_dat_i[7:0];
                    P9_OFS: d.p9 = wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end
        // Scan sequencer
        case (q.st)
            VFD_IDLE: begin
                d.dout = 25'h0;
                d.ks = 1'b0;
                d.slot = 5'd0;
                d.cnt = 13'd0;
                if (q.ctrl[EN_BIT]) begin
                    d.st = VFD_FETCH;
                    d.fidx = 2'd0;
                    d.faddr = 7'd0;
                    d.shadow = 32'h0;
                end
            end
            VFD_FETCH: begin
                // Fetch cycles count into the slot and lie inside its leading blank
                // Pins stay dark so the previous slot's data never leaks in
                d.dout = 25'h0;
                // Gather block bytes, LSB first
                d.shadow[8*q.fidx +: 8] = mem_rd;
                d.faddr = q.faddr + 7'd1;
                d.fidx = q.fidx + 2'd1;
                d.cnt = q.cnt + 13'd1;
                if (q.fidx == bpb) begin
                    d.st = VFD_SHOW;
                end
            end
            VFD_SHOW: begin
                d.cnt = q.cnt + 13'd1;
                if (q.ks) begin
                    // Display data off, port latches on the shared pins 9-24
                    d.dout = port_vals;
                end else if (q.cnt < blank_half || q.cnt >= period - blank_half) begin
                    d.dout = 25'h0;
                end else begin
                    d.dout = q.shadow[24:0] & out_mask;
                end
                if (q.cnt == period - 13'd1) begin
                    d.cnt = 13'd0;
                    d.fidx = 2'd0;
                    d.shadow = 32'h0;
                    if (q.ks) begin
                        d.ks = 1'b0;
                        d.slot = 5'd0;
                        d.faddr = 7'd0;
                        d.st = VFD_FETCH;
                    end else if (q.slot == nslot - 5'd1) begin
                        d.slot = 5'd0;
                        d.faddr = 7'd0;
                        d.ks = q.cfg[KSM_BIT];
                        d.st = q.cfg[KSM_BIT] ? VFD_SHOW : VFD_FETCH;
                    end else begin
                        d.slot = q.slot + 5'd1;
                        d.st = VFD_FETCH;
                    end
                end
            end
            default: d.st = VFD_IDLE;
        endcase
        // Stopped scan: pins act as ordinary port outputs
        if (!q.ctrl[EN_BIT]) begin
            d.st = VFD_IDLE;
            d.ks = 1'b0;
            d.dout = port_vals;
        end
        d.cfg[KSF_BIT] = d.ks;
    end

    // State register
    // Reset is synchronous; register fields load their documented values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= VFD_IDLE;
            q.ctrl <= CTRL_RST;
            q.fmt <= FMT_RST;
            q.cfg <= CFG_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops; the stopped scan loads port latches into dout
    // Trade-off: port latch changes reach the pins one clock late
    assign wb_ack_o = q.ack;
    assign wb_dat_o = {24'h0, q.rdat};
    assign display_out_o = q.dout;
    assign key_scan_active_o = q.cfg[KSF_BIT];

    // Checks: each property guards one rule of the scan or the bus

    // Flag bit 7 mirrors the key-slot state bit
    a_ks_flag_match: assert property (@(posedge clk_i) disable iff (rst_i)
        q.cfg[KSF_BIT] == q.ks)
        else $error("key flag differs from key slot");

    // Key slot: pins 0-8 dark, port latches on 9-24
    a_ks_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.ks && q.st == VFD_SHOW) |=> q.dout == $past(port_vals))
        else $error("key slot pins differ from port latches");

    // Leading blank of a display slot
    a_blank_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.ctrl[EN_BIT] && q.cnt < blank_half) |=> q.dout == 25'h0)
        else $error("output not blanked at slot start");

    // Trailing blank of a display slot
    a_blank_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.ctrl[EN_BIT] && q.cnt >= period - blank_half) |=> q.dout == 25'h0)
        else $error("output not blanked at slot end");

    // Fetch cycles stay dark
    a_fetch_dark: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_FETCH && q.ctrl[EN_BIT]) |=> q.dout == 25'h0)
        else $error("output lit during fetch");

    // Between the blanks the block data shows on the active pins only
    a_lit_window: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.ctrl[EN_BIT] && q.cnt >= blank_half && q.cnt < period - blank_half)
        |=> q.dout == (q.shadow[24:0] & out_mask))
        else $error("lit pins differ from block data");

    // After its fetch each slot has consumed exactly its own block
    a_fetch_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.cnt == 13'(bpb) + 13'd1)
        |-> q.faddr == 7'((7'(q.slot) + 7'd1) * (7'(bpb) + 7'd1)))
        else $error("fetch address off its block");

    // No key slot unless selected
    a_no_ks_insert: assert property (@(posedge clk_i) disable iff (rst_i)
        (!q.cfg[KSM_BIT] && !q.ks) |=> !q.ks)
        else $error("key slot inserted when off");

    // Key slot follows the last display slot when selected
    a_ks_insert: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.ctrl[EN_BIT] && q.cfg[KSM_BIT] && q.slot == nslot - 5'd1
        && q.cnt == period - 13'd1) |=> q.ks)
        else $error("key slot missing after last slot");

    // Flag clears as display timing resumes at slot 0
    a_ks_leave: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.ks && q.ctrl[EN_BIT] && q.st == VFD_SHOW && q.cnt == period - 13'd1)
        |=> (!key_scan_active_o && q.st == VFD_FETCH && q.slot == 5'd0))
        else $error("key flag not cleared at display timing");

    // Slots advance one at a time
    a_slot_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && !q.ks && q.ctrl[EN_BIT] && q.slot != nslot - 5'd1 && q.cnt == period - 13'd1)
        |=> (q.st == VFD_FETCH && q.slot == $past(q.slot) + 5'd1))
        else $error("slot order broken");

    // Slot index stays inside the pattern count
    a_slot_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        q.slot < nslot || q.st == VFD_IDLE || $changed(q.fmt))
        else $error("slot beyond pattern count");

    // Period code picks the slot length
    a_period_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.cfg[1:0] == 2'b00 && period == PER_0) || (q.cfg[1:0] == 2'b01 && period == PER_1)
        || (q.cfg[1:0] == 2'b10 && period == PER_2) || q.cfg[1:0] == 2'b11)
        else $error("slot length differs from period code");

    // Slot counter never runs past the period
    a_period_len: assert property (@(posedge clk_i) disable iff (rst_i)
        q.cnt < period || $changed(q.cfg))
        else $error("slot counter past period");

    // Counter wraps exactly at the period end
    a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == VFD_SHOW && q.ctrl[EN_BIT] && q.cnt == period - 13'd1) |=> q.cnt == 13'd0)
        else $error("slot counter did not wrap");

    // Scan halts when disabled
    a_idle_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.ctrl[EN_BIT] |=> q.st == VFD_IDLE)
        else $error("scan runs while disabled");

    // Stopped scan hands the pins to the port latches
    a_off_ports: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.ctrl[EN_BIT] |=> display_out_o == $past(port_vals))
        else $error("stopped pins differ from port latches");

    // Bus answer is a single-cycle pulse
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        q.ack |=> !q.ack)
        else $error("ack held longer than one cycle");

    // Main scenarios to reach
    c_key_slot: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q.ks));
    c_frame_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
        q.st == VFD_SHOW && q.slot == nslot - 5'd1 && q.cnt == period - 13'd1);
    c_lit: cover property (@(posedge clk_i) disable iff (rst_i) q.dout != 25'h0);
    c_off_ports: cover property (@(posedge clk_i) disable iff (rst_i)
        !q.ctrl[EN_BIT] && q.dout != 25'h0);
    c_short_block: cover property (@(posedge clk_i) disable iff (rst_i)
        q.st == VFD_FETCH && bpb == 2'd2 && q.fidx == 2'd2);
endmodule

// File: vfd_panel_model.sv
`timescale 1ns/100ps
// Panel grids and key matrix, seen from the driver pins
module vfd_panel_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [24:0] drive_i,
    input wire logic key_scan_i,
    output logic [24:0] key_lines_o,
    output logic key_seen_o
);
    // Key matrix sees the shared lines only inside the key slot
    always @(posedge clk_i) begin
        if (clr_i) begin
            key_lines_o <= 25'h0;
            key_seen_o <= 1'b0;
        end else begin
            if (key_scan_i) begin
                key_lines_o <= drive_i;
            end
            // Sticky, so a stray key slot is never missed
            key_seen_o <= key_seen_o | key_scan_i;
        end
    end
endmodule

// File: tb_vfd_scan_controller.sv
`timescale 1ns/100ps
module tb_vfd_scan_controller;
    import vfd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [3:0] wsel = 4'h1;
    logic ack;
    logic ks;
    logic kseen;
    logic kclr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [24:0] dout;
    logic [24:0] keyl;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc_n = 0;
    int t0;
    // Port latch image on outputs 9-24, pins 0-8 low
    localparam logic [31:0] PORTS = {7'h0, 8'h3c, 8'h81, 9'h0};

    vfd_scan_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .display_out_o(dout), .key_scan_active_o(ks));
    vfd_panel_model panel (.clk_i(clk_i), .clr_i(rst_i | kclr), .drive_i(dout), .key_scan_i(ks),
        .key_lines_o(keyl), .key_seen_o(kseen));

    // 100 ns clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Cycle stamp for period measurement
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; holds everything until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            chk(32'h1, 32'h0);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Bounded waits, a miss counts as a mismatch
    task wait_ks(input logic v);
        int n;
        n = 0;
        while (ks !== v && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(ks), 32'(v));
    endtask
    task wait_out(input logic [19:0] e);
        int n;
        n = 0;
        while (dout[19:0] !== e && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(dout[19:0]), 32'(e));
    endtask
    task test_done;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well past the longest scan wait
    initial begin
        #(60000 * 100);
        error_cnt++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL_OFS, 32'h10);
        rd(FMT_OFS, 32'h01);
        rd(CFG_OFS, 32'h00);
        rd(8'h40, 32'h0);
        wb(1'b1, CFG_OFS, 32'hc3);
        rd(CFG_OFS, 32'h43);
        // Eight bytes of pattern: 11h, 22h ... 88h
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, MEM_OFS + 8'(i), 32'(8'h11 * (i + 1)));
        end
        // Last memory byte, not used by the scan
        wb(1'b1, 8'hdf, 32'h5a);
        rd(8'hdf, 32'h5a);
        rd(8'he0, 32'h0);
        // Lane 0 off: the write must be ignored
        wsel = 4'h0;
        wb(1'b1, 8'hdf, 32'hff);
        wsel = 4'h1;
        rd(8'hdf, 32'h5a);
        wb(1'b1, P8_OFS, 32'h3c);
        wb(1'b1, P9_OFS, 32'h81);
        repeat (2) @(posedge clk_i);
        chk(32'(dout), PORTS);
        // Reconfigure only while stopped
        wb(1'b1, CFG_OFS, 32'h42);
        // 4/16 of 1024 clocks, about 25 us of blanking
        wb(1'b1, FMT_OFS, 32'h41);
        wb(1'b1, CTRL_OFS, 32'h98);
        wait_ks(1'b1);
        t0 = cyc_n;
        repeat (100) @(posedge clk_i);
        chk(32'(keyl), PORTS);
        rd(CFG_OFS, 32'hc2);
        wait_ks(1'b0);
        @(posedge clk_i);
        chk(32'(dout), 32'h0);
        repeat (120) @(posedge clk_i);
        chk(32'(dout), 32'h0);
        repeat (380) @(posedge clk_i);
        chk(32'(dout), 32'h0332211);
        repeat (1024) @(posedge clk_i);
        chk(32'(dout), 32'h0776655);
        wait_ks(1'b1);
        chk(32'(cyc_n - t0), 32'd3072);
        wait_ks(1'b0);
        wb(1'b1, CTRL_OFS, 32'h18);
        repeat (2) @(posedge clk_i);
        chk(32'(dout), PORTS);
        kclr <= 1'b1;
        @(posedge clk_i);
        kclr <= 1'b0;
        wb(1'b1, CFG_OFS, 32'h00);
        wb(1'b1, CTRL_OFS, 32'h93);
        wait_out(20'h65544);
        wait_out(20'h32211);
        chk(32'(kseen), 32'h0);
        test_done;
    end
endmodule
